// >>> hdl/frb_pkg.sv
// Package of constants and types for the float register bank and status block.
package frb_pkg;

  // ---------------------------------------------------------------------------
  // Status and control register layout
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FRB_SC_RESET = 32'h00040001;
  localparam int FRB_BANK_BIT = 21;
  localparam int FRB_PAIR_BIT = 20;
  localparam int FRB_DBL_BIT = 19;
  localparam int FRB_DNZ_BIT = 18;
  localparam int FRB_CAUSE_HI = 17;
  localparam int FRB_CAUSE_LO = 12;
  localparam int FRB_EN_HI = 11;
  localparam int FRB_EN_LO = 7;
  localparam int FRB_FLAG_HI = 6;
  localparam int FRB_FLAG_LO = 2;
  localparam int FRB_RND_HI = 1;
  localparam int FRB_RND_LO = 0;
  localparam logic [31:0] FRB_SC_WMASK = 32'h003FFFFF;

  // Exception source order inside the six-bit cause vector: E V Z O U I.
  localparam int FRB_EXC_ERR = 5;
  localparam int FRB_EXC_INX = 0;

  // Rounding codes.
  localparam logic [1:0] FRB_RND_NEAREST = 2'h0;
  localparam logic [1:0] FRB_RND_ZERO = 2'h1;

  // ---------------------------------------------------------------------------
  // Register bank geometry and float formats
  // ---------------------------------------------------------------------------
  localparam int FRB_NREG = 16;
  localparam int FRB_RIDX_W = 4;
  localparam int FRB_MTX_DIM = 4;
  localparam int FRB_SGL_EXP_W = 8;
  localparam int FRB_SGL_FRC_W = 23;
  localparam int FRB_DBL_EXP_W = 11;
  localparam int FRB_DBL_FRC_W = 52;
  localparam logic [10:0] FRB_SGL_EMAX_BIASED = 11'h0FE;
  localparam logic [10:0] FRB_DBL_EMAX_BIASED = 11'h7FE;

  // Access kinds on the core port.
  typedef enum logic [3:0] {
    FRB_ACC_FRONT = 4'h1,
    FRB_ACC_BACK = 4'h2,
    FRB_ACC_SC = 4'h4,
    FRB_ACC_XFER = 4'h8
  } frb_acc_e;

endpackage : frb_pkg

// >>> hdl/frb_round_if.sv
// Interface carrying an unrounded value into the rounding unit and its result out.
`timescale 1ns/100ps
interface frb_round_if;
  logic dbl;
  logic [1:0] mode;
  logic dnz;
  logic sign;
  logic [11:0] exp;
  logic [54:0] mant;
  logic [63:0] result;
  logic ovf;
  logic inx;
  logic unf;
  modport unit (input dbl, mode, dnz, sign, exp, mant, output result, ovf, inx, unf);
  modport user (output dbl, mode, dnz, sign, exp, mant, input result, ovf, inx, unf);
endinterface : frb_round_if

// >>> hdl/frb_round.sv
// Rounding unit: forms the final float from an unrounded value and the mode.
`timescale 1ns/100ps
module frb_round
(
  frb_round_if.unit rif
);

  // ---------------------------------------------------------------------------
  // Mantissa layout: mant[54] is the hidden one, then 52 fraction bits,
  // then a guard bit and a sticky bit. Single uses the top 24 bits.
  // ---------------------------------------------------------------------------
  logic [53:0] kept;
  logic grd;
  logic stk;
  logic lsb;
  logic up;
  logic [54:0] sum;
  logic [11:0] e_adj;
  logic [10:0] emax;
  logic huge;

  // Split off the kept bits and the discarded tail per precision.
  always_comb
  begin
    if (rif.dbl)
    begin
      kept = {1'b0, rif.mant[54:2]};
      grd = rif.mant[1];
      stk = rif.mant[0];
    end
    else
    begin
      kept = {30'h00000000, rif.mant[54:31]};
      grd = rif.mant[30];
      stk = |rif.mant[29:0];
    end
    lsb = kept[0];
  end

  // Ties go to the even neighbour; truncation never rounds up.
  always_comb
  begin
    if (rif.mode == frb_pkg::FRB_RND_NEAREST)
      up = grd & (stk | lsb);
    else
      up = 1'b0;
  end

  // A carry out of the mantissa bumps the exponent.
  always_comb
  begin
    sum = {1'b0, kept} + {54'h0, up};
    if (rif.dbl ? sum[53] : sum[24])
      e_adj = rif.exp + 12'h001;
    else
      e_adj = rif.exp;
    emax = rif.dbl ? frb_pkg::FRB_DBL_EMAX_BIASED : frb_pkg::FRB_SGL_EMAX_BIASED;
    huge = (e_adj > {1'b0, emax});
  end

  // Pack the result, handling overflow by mode and underflow by denormal mode.
  always_comb
  begin
    rif.ovf = huge;
    rif.inx = grd | stk | huge;
    rif.unf = (rif.exp == 12'h000) & (|rif.mant);
    rif.result = 64'h0;
    if (huge)
    begin
      if (rif.mode == frb_pkg::FRB_RND_ZERO)
        // Saturate to the largest finite magnitude.
        rif.result = rif.dbl ? {rif.sign, emax, {52{1'b1}}}
                             : {32'h0, rif.sign, emax[7:0], {23{1'b1}}};
      else
        rif.result = rif.dbl ? {rif.sign, {11{1'b1}}, 52'h0}
                             : {32'h0, rif.sign, 8'hFF, 23'h0};
    end
    else if (rif.unf & rif.dnz)
      rif.result = rif.dbl ? {rif.sign, 63'h0} : {32'h0, rif.sign, 31'h0};
    else if (rif.dbl)
      rif.result = {rif.sign, e_adj[10:0],
                    (sum[53] ? sum[52:1] : sum[51:0])};
    else
      rif.result = {32'h0, rif.sign, e_adj[7:0],
                    (sum[24] ? sum[23:1] : sum[22:0])};
  end

endmodule : frb_round

// >>> hdl/frb_top.sv
// Float register bank with bank-swap views, status/control and transfer registers.
// Notes on behaviour
// - back bank read as column-major 4x4 matrix
// - status register 32 bits, resets to 00040001
// - bits 22..31 read zero, write zero
// - bit 21 swaps front and back banks
// - bit 20 selects 32 or 64 bit moves; only reads follow it, core writes pair by wr_pair
// - bit 19 selects single or double precision
// - bit 18 flushes denormals to zero
// - cause bits 17..12: E V Z O U I
// - enable bits 11..7, no error enable
// - flag bits 6..2, no error flag
// - cause cleared at each operation start
// - exception sets cause and sticky flag
// - transfer register via sysreg load/store only
// - rounding once when forming final result
// - nearest mode ties go to even
// - nearest mode overflow gives signed infinity
// - zero mode truncates below round position
// - zero mode overflow saturates to maximum
// - pairs even/odd
`timescale 1ns/100ps
module frb_top
(
  input wire logic clock,
  input wire logic rst_n,
  // Register write port.
  input wire logic wr_en,
  input wire frb_pkg::frb_acc_e wr_kind,
  input wire logic [3:0] wr_idx,
  input wire logic wr_pair,
  input wire logic [63:0] wr_data,
  // Register read port.
  input wire logic rd_en,
  input wire frb_pkg::frb_acc_e rd_kind,
  input wire logic [3:0] rd_idx,
  output logic [63:0] rd_data,
  output logic rd_valid,
  // Back-bank matrix view, column-major, sixteen words.
  output logic [511:0] back_matrix_view,
  // Operation start and exception report.
  input wire logic op_start,
  input wire logic [5:0] exc_src,
  input wire logic exc_valid,
  // Rounding request: unrounded value and destination front register.
  input wire logic rnd_req,
  input wire logic [3:0] rnd_dst,
  input wire logic rnd_sign,
  input wire logic [11:0] rnd_exp,
  input wire logic [54:0] rnd_mant,
  output logic rnd_exc_pending,
  // Mode outputs.
  output logic register_bank_select,
  output logic pair_move_select,
  output logic double_width_select,
  output logic denormal_zero_select,
  output logic [1:0] rounding_select,
  output logic mode_reserved
);

  // ---------------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;
  logic rstn;

  // Two stages keep the release synchronous to the clock.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rstn = rst_s2_r;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [31:0] bank0_r [frb_pkg::FRB_NREG];
  logic [31:0] bank1_r [frb_pkg::FRB_NREG];
  logic [31:0] fpu_status_control_r;
  logic [31:0] fpu_status_control_nxt;
  logic [31:0] fpu_cpu_transfer_r;

  // Physical bank that a view reaches; front is bank 0 unless swapped.
  function automatic logic phys_bank
  (
    input logic back,
    input logic swap
  );
    phys_bank = back ^ swap;
  endfunction : phys_bank

  // Pair base: clears the low index bit so pairs are even then odd.
  function automatic logic [3:0] pair_base
  (
    input logic [3:0] idx
  );
    pair_base = {idx[3:1], 1'b0};
  endfunction : pair_base

  // ---------------------------------------------------------------------------
  // Rounding unit
  // ---------------------------------------------------------------------------
  frb_round_if rif ();
  assign rif.dbl = double_width_select;
  assign rif.mode = rounding_select;
  assign rif.dnz = denormal_zero_select;
  assign rif.sign = rnd_sign;
  assign rif.exp = rnd_exp;
  assign rif.mant = rnd_mant;

  frb_round u_round
  (
    .rif(rif)
  );

  // Mode fields straight from the register, so all take effect together.
  assign register_bank_select = fpu_status_control_r[frb_pkg::FRB_BANK_BIT];
  assign pair_move_select = fpu_status_control_r[frb_pkg::FRB_PAIR_BIT];
  assign double_width_select = fpu_status_control_r[frb_pkg::FRB_DBL_BIT];
  assign denormal_zero_select = fpu_status_control_r[frb_pkg::FRB_DNZ_BIT];
  assign rounding_select = fpu_status_control_r[frb_pkg::FRB_RND_HI:frb_pkg::FRB_RND_LO];
  // Flags the reserved pair+double combination and reserved rounding codes.
  assign mode_reserved = (pair_move_select & double_width_select)
                         | rounding_select[1];

  // ---------------------------------------------------------------------------
  // Status and control next value
  // ---------------------------------------------------------------------------
  logic [5:0] cause_new;
  logic [4:0] flag_new;
  logic [5:0] rnd_exc;

  // Exceptions from the rounding unit: overflow, underflow, inexact.
  assign rnd_exc = rnd_req ? {3'h0, rif.ovf, rif.unf, rif.inx} : 6'h00;

  always_comb
  begin
    fpu_status_control_nxt = fpu_status_control_r;
    cause_new = fpu_status_control_r[frb_pkg::FRB_CAUSE_HI:frb_pkg::FRB_CAUSE_LO];
    if (op_start)
      cause_new = 6'h00;
    if (exc_valid)
      cause_new = cause_new | exc_src;
    cause_new = cause_new | rnd_exc;
    flag_new = fpu_status_control_r[frb_pkg::FRB_FLAG_HI:frb_pkg::FRB_FLAG_LO];
    if (wr_en && wr_kind == frb_pkg::FRB_ACC_SC)
    begin
      // Whole word lands in one edge; reserved bits are dropped.
      fpu_status_control_nxt = wr_data[31:0] & frb_pkg::FRB_SC_WMASK;
      flag_new = wr_data[frb_pkg::FRB_FLAG_HI:frb_pkg::FRB_FLAG_LO];
      if (!(op_start | exc_valid | rnd_req))
        cause_new = wr_data[frb_pkg::FRB_CAUSE_HI:frb_pkg::FRB_CAUSE_LO];
    end
    // A new exception wins over a software clear of the same flag.
    if (exc_valid)
      flag_new = flag_new | exc_src[frb_pkg::FRB_EXC_ERR-1:frb_pkg::FRB_EXC_INX];
    flag_new = flag_new | rnd_exc[4:0];
    fpu_status_control_nxt[frb_pkg::FRB_CAUSE_HI:frb_pkg::FRB_CAUSE_LO] = cause_new;
    fpu_status_control_nxt[frb_pkg::FRB_FLAG_HI:frb_pkg::FRB_FLAG_LO] = flag_new;
  end

  // Status and control register.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fpu_status_control_r <= frb_pkg::FRB_SC_RESET;
    end
    else
    begin
      fpu_status_control_r <= fpu_status_control_nxt;
    end
  end

  // Error cause, or any enabled exception among the recorded causes.
  assign rnd_exc_pending = fpu_status_control_r[frb_pkg::FRB_CAUSE_HI]
    | |(fpu_status_control_r[frb_pkg::FRB_CAUSE_HI-1:frb_pkg::FRB_CAUSE_LO]
        & fpu_status_control_r[frb_pkg::FRB_EN_HI:frb_pkg::FRB_EN_LO]);

  // ---------------------------------------------------------------------------
  // Transfer register
  // ---------------------------------------------------------------------------
  // Only sysreg load writes it; no other path reaches it.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fpu_cpu_transfer_r <= 32'h00000000;
    end
    else if (wr_en && wr_kind == frb_pkg::FRB_ACC_XFER)
    begin
      fpu_cpu_transfer_r <= wr_data[31:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Float register banks
  // ---------------------------------------------------------------------------
  logic wr_bank;
  logic wr_view;
  logic [3:0] wr_lo;

  // Decide where a core write lands.
  always_comb
  begin
    wr_view = (wr_kind == frb_pkg::FRB_ACC_BACK);
    wr_bank = phys_bank(wr_view, register_bank_select);
    wr_lo = wr_pair ? pair_base(wr_idx) : wr_idx;
  end

  // Pair writes put the high word in the even register, low in the odd.
  // The rounding result goes to the front bank; a core write same cycle wins.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < frb_pkg::FRB_NREG; i++)
      begin
        bank0_r[i] <= 32'h00000000;
        bank1_r[i] <= 32'h00000000;
      end
    end
    else
    begin
      if (rnd_req)
      begin
        if (double_width_select)
        begin
          if (register_bank_select)
          begin
            bank1_r[pair_base(rnd_dst)] <= rif.result[63:32];
            bank1_r[pair_base(rnd_dst) | 4'h1] <= rif.result[31:0];
          end
          else
          begin
            bank0_r[pair_base(rnd_dst)] <= rif.result[63:32];
            bank0_r[pair_base(rnd_dst) | 4'h1] <= rif.result[31:0];
          end
        end
        else if (register_bank_select)
          bank1_r[rnd_dst] <= rif.result[31:0];
        else
          bank0_r[rnd_dst] <= rif.result[31:0];
      end
      if (wr_en && (wr_kind == frb_pkg::FRB_ACC_FRONT || wr_view))
      begin
        if (wr_pair)
        begin
          if (wr_bank)
          begin
            bank1_r[wr_lo] <= wr_data[63:32];
            bank1_r[wr_lo | 4'h1] <= wr_data[31:0];
          end
          else
          begin
            bank0_r[wr_lo] <= wr_data[63:32];
            bank0_r[wr_lo | 4'h1] <= wr_data[31:0];
          end
        end
        else if (wr_bank)
          bank1_r[wr_lo] <= wr_data[31:0];
        else
          bank0_r[wr_lo] <= wr_data[31:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  logic rd_bank;
  logic [3:0] rd_lo;
  logic [63:0] rd_nxt;

  // Pair reads follow the pair-move mode bit.
  always_comb
  begin
    rd_bank = phys_bank(rd_kind == frb_pkg::FRB_ACC_BACK, register_bank_select);
    rd_lo = pair_move_select ? pair_base(rd_idx) : rd_idx;
    rd_nxt = 64'h0;
    if (rd_kind == frb_pkg::FRB_ACC_SC)
      rd_nxt = {32'h0, fpu_status_control_r & frb_pkg::FRB_SC_WMASK};
    else if (rd_kind == frb_pkg::FRB_ACC_XFER)
      rd_nxt = {32'h0, fpu_cpu_transfer_r};
    else if (pair_move_select)
      rd_nxt = rd_bank ? {bank1_r[rd_lo], bank1_r[rd_lo | 4'h1]}
                       : {bank0_r[rd_lo], bank0_r[rd_lo | 4'h1]};
    else
      rd_nxt = {32'h0, (rd_bank ? bank1_r[rd_lo] : bank0_r[rd_lo])};
  end

  // Read data registered; valid one cycle after the request.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data <= 64'h0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
      begin
        rd_data <= rd_nxt;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Matrix view of the back bank
  // ---------------------------------------------------------------------------
  // Word c*4+r is column c, row r: column-major, registered.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      back_matrix_view <= '0;
    end
    else
    begin
      for (int c = 0; c < frb_pkg::FRB_MTX_DIM; c++)
        for (int r = 0; r < frb_pkg::FRB_MTX_DIM; r++)
          back_matrix_view[(c*frb_pkg::FRB_MTX_DIM+r)*32 +: 32] <=
            register_bank_select ? bank0_r[c*frb_pkg::FRB_MTX_DIM+r]
                                 : bank1_r[c*frb_pkg::FRB_MTX_DIM+r];
    end
  end

endmodule : frb_top

// >>> bench/frb_monitor.sv
// Checker of the float register bank port behaviour.
`timescale 1ns/100ps
module frb_monitor
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire frb_pkg::frb_acc_e wr_kind,
  input wire logic [3:0] wr_idx,
  input wire logic wr_pair,
  input wire logic [63:0] wr_data,
  input wire logic rd_en,
  input wire frb_pkg::frb_acc_e rd_kind,
  input wire logic [63:0] rd_data,
  input wire logic rd_valid,
  input wire logic [511:0] back_matrix_view,
  input wire logic op_start,
  input wire logic [5:0] exc_src,
  input wire logic exc_valid,
  input wire logic rnd_req,
  input wire logic rnd_exc_pending,
  input wire logic register_bank_select,
  input wire logic pair_move_select,
  input wire logic double_width_select,
  input wire logic denormal_zero_select,
  input wire logic [1:0] rounding_select,
  input wire logic mode_reserved
);
  // ---------------------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Mode bits gathered in register order so one compare covers a whole write.
  wire logic [5:0] modes = {register_bank_select, pair_move_select, double_width_select,
    denormal_zero_select, rounding_select};
  sequence s_sc_wr; wr_en && wr_kind == frb_pkg::FRB_ACC_SC; endsequence
  sequence s_back_wr; wr_en && wr_kind == frb_pkg::FRB_ACC_BACK && !wr_pair; endsequence
  sequence s_clear; op_start && !exc_valid && !rnd_req; endsequence
  sequence s_err; exc_valid && exc_src[5]; endsequence
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered in one cycle");
  a_read_idle: assert property (!rd_en |=> !rd_valid && $stable(rd_data))
    else $error("read data moved without a read");
  a_sc_reserved: assert property (rd_en && rd_kind == frb_pkg::FRB_ACC_SC |=> rd_data[31:22] == 10'h000)
    else $error("reserved status bits read nonzero");
  a_mode_write: assert property (s_sc_wr |=> modes == $past({wr_data[21:18], wr_data[1:0]}))
    else $error("modes not taken from status write");
  a_mode_hold: assert property (!$stable(modes) |-> $past(wr_en && wr_kind == frb_pkg::FRB_ACC_SC))
    else $error("modes changed without status write");
  a_mode_reserved: assert property (mode_reserved == ((pair_move_select && double_width_select) || rounding_select[1]))
    else $error("reserved mode flag wrong");
  a_cause_clear: assert property (s_clear |-> ##[1:2] !rnd_exc_pending)
    else $error("cause not cleared at operation start");
  a_err_pending: assert property (s_err |-> ##[1:2] rnd_exc_pending)
    else $error("error source not pending");
  a_matrix_col: assert property (s_back_wr |-> ##2 back_matrix_view[$past(wr_idx, 2) * 32 +: 32] == $past(wr_data[31:0], 2))
    else $error("matrix word does not follow back write");
endmodule : frb_monitor

// >>> bench/frb_core_model.sv
// Core-side model issuing register and system-register transfers.
`timescale 1ns/100ps
module frb_core_model
(
  input wire logic clock,
  input wire logic rd_valid,
  input wire logic [63:0] rd_data,
  output logic wr_en = 1'b0,
  output frb_pkg::frb_acc_e wr_kind = frb_pkg::FRB_ACC_FRONT,
  output logic [3:0] wr_idx = 4'h0,
  output logic wr_pair = 1'b0,
  output logic [63:0] wr_data = 64'h0,
  output logic rd_en = 1'b0,
  output frb_pkg::frb_acc_e rd_kind = frb_pkg::FRB_ACC_FRONT,
  output logic [3:0] rd_idx = 4'h0
);
  // One write pulse; released index and data are inverted so stale values never match.
  task automatic wr(input frb_pkg::frb_acc_e k, input logic [3:0] i, input logic p,
    input logic [63:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    wr_kind = k;
    wr_idx = i;
    wr_pair = p;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
    wr_idx = ~i;
    wr_data = ~d;
  endtask : wr
  // One read pulse; the answer is awaited for a few cycles only.
  task automatic rd(input frb_pkg::frb_acc_e k, input logic [3:0] i, output logic [63:0] d,
    output logic ok);
    ok = 1'b0;
    d = 64'h0;
    @(negedge clock);
    rd_en = 1'b1;
    rd_kind = k;
    rd_idx = i;
    @(negedge clock);
    rd_en = 1'b0;
    rd_idx = ~i;
    for (int n = 0; n < 3 && !ok; n++)
    begin
      if (rd_valid === 1'b1)
      begin
        ok = 1'b1;
        d = rd_data;
      end
      else
        @(negedge clock);
    end
  endtask : rd
endmodule : frb_core_model

// >>> bench/tb_top.sv
// Self-checking bench for the float register bank and status block.
`timescale 1ns/100ps
module tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic op_start = 1'b0;
  logic exc_valid = 1'b0;
  logic [5:0] exc_src = 6'h00;
  logic rnd_req = 1'b0;
  logic [3:0] rnd_dst = 4'h0;
  logic rnd_sign = 1'b0;
  logic [11:0] rnd_exp = 12'h000;
  logic [54:0] rnd_mant = 55'h0;
  logic wr_en, wr_pair, rd_en, rd_valid, rnd_exc_pending, mode_reserved;
  frb_pkg::frb_acc_e wr_kind, rd_kind;
  logic [3:0] wr_idx, rd_idx;
  logic [63:0] wr_data, rd_data;
  logic [511:0] back_matrix_view;
  logic [1:0] rounding_select;
  logic register_bank_select, pair_move_select, double_width_select, denormal_zero_select;
  logic [31:0] bk [2][16];
  logic [31:0] sc_m;
  integer seed = 32'h532a;
  int fails = 0;
  int compares = 0;
  localparam frb_pkg::frb_acc_e SC = frb_pkg::FRB_ACC_SC;

  // Core clock at 40 MHz.
  always #12.5 clock = ~clock;

  frb_top i_dut (.clock(clock), .rst_n(rst_n), .wr_en(wr_en), .wr_kind(wr_kind),
    .wr_idx(wr_idx), .wr_pair(wr_pair), .wr_data(wr_data), .rd_en(rd_en), .rd_kind(rd_kind),
    .rd_idx(rd_idx), .rd_data(rd_data), .rd_valid(rd_valid), .op_start(op_start),
    .back_matrix_view(back_matrix_view), .exc_src(exc_src), .exc_valid(exc_valid),
    .rnd_req(rnd_req), .rnd_dst(rnd_dst), .rnd_sign(rnd_sign), .rnd_exp(rnd_exp),
    .rnd_mant(rnd_mant), .rnd_exc_pending(rnd_exc_pending), .mode_reserved(mode_reserved),
    .register_bank_select(register_bank_select), .pair_move_select(pair_move_select),
    .double_width_select(double_width_select), .rounding_select(rounding_select),
    .denormal_zero_select(denormal_zero_select));
  frb_core_model i_core (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .wr_en(wr_en), .wr_kind(wr_kind), .wr_idx(wr_idx), .wr_pair(wr_pair), .wr_data(wr_data),
    .rd_en(rd_en), .rd_kind(rd_kind), .rd_idx(rd_idx));

  // Expected single result: ties go to the even value, zero mode truncates.
  function automatic logic [31:0] rexp(input logic z, input logic s, input logic [11:0] e,
    input logic [54:0] x);
    logic [31:0] f;
    f = {s, e[7:0], x[53:31]};
    if (e > 12'h0FE)
      return z ? {s, 31'h7F7FFFFF} : {s, 31'h7F800000};
    if (z)
      return f;
    return f + {31'h0, x[30] & ((|x[29:0]) | f[0])};
  endfunction : rexp

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic rchk(input frb_pkg::frb_acc_e k, input logic [3:0] i, input logic [63:0] e,
    input logic [63:0] m);
    logic [63:0] d;
    logic ok;
    i_core.rd(k, i, d, ok);
    chk({63'h0, ok}, 64'h1);
    chk(d & m, e & m);
  endtask : rchk

  task automatic sc_wr(input logic [31:0] v);
    i_core.wr(SC, 4'h0, 1'b0, {32'h0, v});
    sc_m = v & frb_pkg::FRB_SC_WMASK;
  endtask : sc_wr

  // One operation-start and exception report pulse.
  task automatic ev(input logic o, input logic [5:0] s);
    @(negedge clock);
    op_start = o;
    exc_valid = |s;
    exc_src = s;
    @(negedge clock);
    op_start = 1'b0;
    exc_valid = 1'b0;
    exc_src = ~s;
  endtask : ev

  // Rounds one value into a random front register and reads it back.
  task automatic rnd(input logic [11:0] e, input logic [54:0] x);
    logic [3:0] d;
    logic s;
    d = $random(seed);
    s = $random(seed);
    @(negedge clock);
    rnd_req = 1'b1;
    rnd_dst = d;
    rnd_sign = s;
    rnd_exp = e;
    rnd_mant = x;
    @(negedge clock);
    rnd_req = 1'b0;
    rnd_exp = ~e;
    rnd_mant = ~x;
    bk[sc_m[21]][d] = rexp(sc_m[0], s, e, x);
    rchk(frb_pkg::FRB_ACC_FRONT, d, {32'h0, bk[sc_m[21]][d]}, 64'hFFFFFFFF);
  endtask : rnd

  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    logic [31:0] v;
    logic [63:0] e;
    logic [5:0] fl;
    logic [3:0] i;
    logic p;
    frb_pkg::frb_acc_e kd;
    logic [66:0] cs [5];
    cs = '{{12'h080, 1'b1, 23'h0, 1'b1, 30'h0}, {12'h080, 1'b1, 23'h1, 1'b1, 30'h0},
      {12'h090, 1'b1, 23'h2, 1'b1, 30'h1}, {12'h0FE, 1'b1, 23'h7FFFFF, 1'b1, 30'h0},
      {12'h0FF, 55'h40000000000000}};
    foreach (bk[b, j])
      bk[b][j] = 32'h0;
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
    rchk(SC, 4'h0, {32'h0, frb_pkg::FRB_SC_RESET}, '1);
    rchk(frb_pkg::FRB_ACC_XFER, 4'h0, 64'h0, 64'hFFFFFFFF);
    sc_wr(32'hFFC00001);
    rchk(SC, 4'h0, 64'h1, '1);
    // Random modes, reserved rounding codes included; pair and double never set together.
    for (int k = 0; k < 8; k++)
    begin
      v = $random(seed) & frb_pkg::FRB_SC_WMASK;
      if (v[20])
        v[19] = 1'b0;
      sc_wr(v);
      rchk(SC, 4'h0, {32'h0, v}, '1);
      chk({register_bank_select, pair_move_select, double_width_select, denormal_zero_select,
        rounding_select, mode_reserved}, {v[21:18], v[1:0], v[1]});
      v = $random(seed);
      i_core.wr(frb_pkg::FRB_ACC_XFER, 4'h0, 1'b0, {~v, v});
      rchk(frb_pkg::FRB_ACC_XFER, 4'h0, {32'h0, v}, 64'hFFFFFFFF);
    end
    // Bank traffic through both views under every bank and size setting.
    for (int k = 0; k < 48; k++)
    begin
      if (k % 8 == 0)
        sc_wr({10'h0, k[3], k[4], 20'h0});
      i = $random(seed);
      p = $random(seed);
      e = {$random(seed), $random(seed)};
      kd = k[1] ? frb_pkg::FRB_ACC_BACK : frb_pkg::FRB_ACC_FRONT;
      if (p)
        i[0] = 1'b0;
      i_core.wr(kd, i, p, e);
      if (p)
        bk[sc_m[21] ^ k[1]][i | 4'h1] = e[31:0];
      bk[sc_m[21] ^ k[1]][i] = p ? e[63:32] : e[31:0];
      i = $random(seed);
      if (sc_m[20])
        i[0] = 1'b0;
      kd = k[2] ? frb_pkg::FRB_ACC_BACK : frb_pkg::FRB_ACC_FRONT;
      e = {bk[sc_m[21] ^ k[2]][i], bk[sc_m[21] ^ k[2]][i | 4'h1]};
      rchk(kd, i, sc_m[20] ? e : {32'h0, e[63:32]}, sc_m[20] ? '1 : 64'hFFFFFFFF);
    end
    repeat (2) @(negedge clock);
    for (int k = 0; k < 16; k++)
      chk(back_matrix_view[k * 32 +: 32], bk[~sc_m[21]][k]);
    // Each exception source sets its cause; flags accumulate.
    sc_wr(32'h0);
    fl = 6'h00;
    for (int k = 0; k < 6; k++)
    begin
      ev(1'b1, 6'h01 << k);
      fl = fl | ((6'h01 << k) & 6'h1F);
      rchk(SC, 4'h0, {32'h0, 14'h0, 6'h01 << k, 5'h0, fl[4:0], 2'h0}, '1);
    end
    ev(1'b1, 6'h00);
    rchk(SC, 4'h0, {32'h0, 25'h0, fl[4:0], 2'h0}, '1);
    sc_wr(32'h00000080);
    ev(1'b1, 6'h01);
    chk({63'h0, rnd_exc_pending}, 64'h1);
    ev(1'b1, 6'h00);
    chk({63'h0, rnd_exc_pending}, 64'h0);
    // Corner and random rounding in both modes.
    for (int k = 0; k < 2; k++)
    begin
      sc_wr({31'h0, k[0]});
      for (int j = 0; j < 13; j++)
      begin
        v = $random(seed);
        if (j < 5)
          rnd(cs[j][66:55], cs[j][54:0]);
        else
          rnd({5'h0, v[6:1], 1'b1}, {1'b1, v[31:10], 32'($random(seed))});
      end
      rchk(SC, 4'h0, 64'h10, 64'h10);
    end
    summarize();
  end
endmodule : tb_top

bind frb_top frb_monitor i_mon (.clock(clock), .rst_n(rst_n), .wr_en(wr_en),
  .wr_kind(wr_kind), .wr_idx(wr_idx), .wr_pair(wr_pair), .wr_data(wr_data), .rd_en(rd_en),
  .rd_kind(rd_kind), .rd_data(rd_data), .rd_valid(rd_valid), .op_start(op_start),
  .back_matrix_view(back_matrix_view), .exc_src(exc_src), .exc_valid(exc_valid),
  .rnd_req(rnd_req), .rnd_exc_pending(rnd_exc_pending), .mode_reserved(mode_reserved),
  .register_bank_select(register_bank_select), .pair_move_select(pair_move_select),
  .double_width_select(double_width_select), .rounding_select(rounding_select),
  .denormal_zero_select(denormal_zero_select));
